// >>> common/jisr_pkg.sv
// Shared constants and types of the scan and in-system programming port.
package jisr_pkg;

  // ----------------------------------------------------------------------
  // Register lengths
  // ----------------------------------------------------------------------
  localparam int IR_LEN  = 10;
  localparam int ID_LEN  = 32;
  localparam int BSR_LEN = 96;
  localparam int CNT_W   = 22;

  // ----------------------------------------------------------------------
  // Identification fields, most significant first
  // ----------------------------------------------------------------------
  localparam int ID_VER_W  = 4;
  localparam int ID_PART_W = 16;
  localparam int ID_MFR_W  = 11;
  localparam logic ID_LSB  = 1'b1;

  // ----------------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------------
  localparam logic [IR_LEN-1:0] INS_EXTEST   = 10'h000;
  localparam logic [IR_LEN-1:0] INS_SAMPLE   = 10'h005;
  localparam logic [IR_LEN-1:0] INS_USERCODE = 10'h007;
  localparam logic [IR_LEN-1:0] INS_IDCODE   = 10'h059;
  localparam logic [IR_LEN-1:0] INS_ENTER    = 10'h202;
  localparam logic [IR_LEN-1:0] INS_EXIT     = 10'h201;
  localparam logic [IR_LEN-1:0] INS_ERASE    = 10'h3F2;
  localparam logic [IR_LEN-1:0] INS_PROGRAM  = 10'h3F4;
  localparam logic [IR_LEN-1:0] INS_VERIFY   = 10'h3F5;
  localparam logic [IR_LEN-1:0] INS_BYPASS   = 10'h3FF;
  localparam logic [1:0]        IR_CAP_LOW   = 2'h1;

  // ----------------------------------------------------------------------
  // Pulse timing at the system clock
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ     = 20;
  localparam int MODE_US     = 1000;
  localparam int ERASE_US    = 100000;
  localparam int PROGRAM_US  = 100;
  localparam int READ_US     = 10;
  localparam int MODE_CYC    = MODE_US * CLK_MHZ;
  localparam int ERASE_CYC   = ERASE_US * CLK_MHZ;
  localparam int PROGRAM_CYC = PROGRAM_US * CLK_MHZ;
  localparam int READ_CYC    = READ_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_EXIT2_DR = 4'h0, TAP_EXIT1_DR = 4'h1, TAP_SHIFT_DR = 4'h2, TAP_PAUSE_DR = 4'h3,
    TAP_SEL_IR   = 4'h4, TAP_UPD_DR   = 4'h5, TAP_CAP_DR   = 4'h6, TAP_SEL_DR   = 4'h7,
    TAP_EXIT2_IR = 4'h8, TAP_EXIT1_IR = 4'h9, TAP_SHIFT_IR = 4'hA, TAP_PAUSE_IR = 4'hB,
    TAP_IDLE     = 4'hC, TAP_UPD_IR   = 4'hD, TAP_CAP_IR   = 4'hE, TAP_RESET    = 4'hF
  } jisr_tap_type;

  typedef enum logic [2:0] {
    PK_NONE    = 3'h0,
    PK_ENTER   = 3'h1,
    PK_EXIT    = 3'h2,
    PK_ERASE   = 3'h3,
    PK_PROGRAM = 3'h4,
    PK_VERIFY  = 3'h5
  } jisr_pulse_type;

endpackage

// >>> logic/jisr_sync.sv
// Three-stage synchroniser that passes a level once two stages agree.
`timescale 1ns/1ns
module jisr_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } jisr_sync_type;

  jisr_sync_type st_ff;
  jisr_sync_type nxt_st;

  // The first stage feeds only the second; the output moves on agreement.
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.q = st_ff.s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;

endmodule

// >>> logic/jisr_top.sv
// Test access port with scan registers and the programming pulse engine.
// Overview of operation
// - Every stage but the identification check includes a timed pulse besides the shifting.
// - Instruction register is exactly 10 bits between TDI and TDO.
// - Identification and user-code registers are 32 bits each.
// - Boundary-scan length is a size parameter: 96, 192, 288, 480 or 624.
// - Identification is version 4, part 16, maker 11, then one fixed bit.
// - Identification fields are written MSB leftmost; version on top.
// - Identification bit 0 always reads as one.
// - Commands and data enter on TDI; results leave on TDO.
// - Six stages in order; entry and exit each last 1 ms. The order is not enforced: no pulse is gated by the programming mode.
// - Bulk erase is erase instructions followed by one 100 ms pulse.
`timescale 1ns/1ns
module jisr_top #(
  parameter int              BSR_LEN   = jisr_pkg::BSR_LEN,
  parameter int              MODE_CYC  = jisr_pkg::MODE_CYC,
  parameter int              ERASE_CYC = jisr_pkg::ERASE_CYC,
  parameter logic [3:0]      ID_VER    = 4'h3,
  parameter logic [15:0]     ID_PART   = 16'hA5C3,
  parameter logic [10:0]     ID_MFR    = 11'h2B5
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  input  wire logic [31:0]        user_code,
  input  wire logic [BSR_LEN-1:0] bsr_pins_in,
  output logic      [BSR_LEN-1:0] bsr_pins_out,
  output logic                    extest_en,
  output logic                    in_system_programming_mode,
  output logic                    erase_pulse,
  output logic                    program_pulse,
  output logic                    read_pulse,
  output logic      [15:0]        cell_addr,
  output logic      [15:0]        cell_wdata,
  input  wire logic [15:0]        cell_rdata
);

  // ----------------------------------------------------------------------
  // Link side state, clocked by TCK
  // ----------------------------------------------------------------------
  typedef struct packed {
    jisr_pkg::jisr_tap_type           tap;
    logic [jisr_pkg::IR_LEN-1:0]      ir_sh;
    logic [jisr_pkg::IR_LEN-1:0]      ir;
    logic [jisr_pkg::ID_LEN-1:0]      dr32;
    logic                             byp;
    logic [BSR_LEN-1:0]               bsr_sh;
    logic [BSR_LEN-1:0]               bsr_upd;
    logic [31:0]                      word;
    jisr_pkg::jisr_pulse_type         kind;
    logic                             req_tog;
  } jisr_link_type;

  // ----------------------------------------------------------------------
  // System side state, clocked by clk_sys
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                             busy;
    jisr_pkg::jisr_pulse_type         kind;
    logic [jisr_pkg::CNT_W-1:0]       cnt;
    logic                             ack_tog;
    logic                             mode;
    logic [15:0]                      addr;
    logic [15:0]                      wdata;
    logic [15:0]                      rdata;
  } jisr_sys_type;

  jisr_link_type lk_ff;
  jisr_link_type nxt_lk;
  jisr_sys_type  sy_ff;
  jisr_sys_type  nxt_sy;
  logic          tdo_ff;
  logic          tdo_oe_ff;
  logic          nxt_tdo;
  logic          ack_seen;
  logic          req_seen;
  logic          link_busy;
  logic [31:0]   id_value;

  // Version on top, maker below the part number, constant one at bit 0.
  assign id_value = {ID_VER, ID_PART, ID_MFR, jisr_pkg::ID_LSB};

  jisr_sync u_ack_sync (
    .clk   (tck),
    .rst_n (rst_n),
    .d     (sy_ff.ack_tog),
    .q     (ack_seen)
  );

  jisr_sync u_req_sync (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .d     (lk_ff.req_tog),
    .q     (req_seen)
  );

  // A pulse is outstanding from our toggle until its acknowledge returns.
  assign link_busy = lk_ff.req_tog ^ ack_seen;

  function automatic jisr_pkg::jisr_tap_type tap_next(jisr_pkg::jisr_tap_type s, logic m);
    case (s)
      jisr_pkg::TAP_RESET:    tap_next = m ? jisr_pkg::TAP_RESET    : jisr_pkg::TAP_IDLE;
      jisr_pkg::TAP_IDLE:     tap_next = m ? jisr_pkg::TAP_SEL_DR   : jisr_pkg::TAP_IDLE;
      jisr_pkg::TAP_SEL_DR:   tap_next = m ? jisr_pkg::TAP_SEL_IR   : jisr_pkg::TAP_CAP_DR;
      jisr_pkg::TAP_CAP_DR:   tap_next = m ? jisr_pkg::TAP_EXIT1_DR : jisr_pkg::TAP_SHIFT_DR;
      jisr_pkg::TAP_SHIFT_DR: tap_next = m ? jisr_pkg::TAP_EXIT1_DR : jisr_pkg::TAP_SHIFT_DR;
      jisr_pkg::TAP_EXIT1_DR: tap_next = m ? jisr_pkg::TAP_UPD_DR   : jisr_pkg::TAP_PAUSE_DR;
      jisr_pkg::TAP_PAUSE_DR: tap_next = m ? jisr_pkg::TAP_EXIT2_DR : jisr_pkg::TAP_PAUSE_DR;
      jisr_pkg::TAP_EXIT2_DR: tap_next = m ? jisr_pkg::TAP_UPD_DR   : jisr_pkg::TAP_SHIFT_DR;
      jisr_pkg::TAP_UPD_DR:   tap_next = m ? jisr_pkg::TAP_SEL_DR   : jisr_pkg::TAP_IDLE;
      jisr_pkg::TAP_SEL_IR:   tap_next = m ? jisr_pkg::TAP_RESET    : jisr_pkg::TAP_CAP_IR;
      jisr_pkg::TAP_CAP_IR:   tap_next = m ? jisr_pkg::TAP_EXIT1_IR : jisr_pkg::TAP_SHIFT_IR;
      jisr_pkg::TAP_SHIFT_IR: tap_next = m ? jisr_pkg::TAP_EXIT1_IR : jisr_pkg::TAP_SHIFT_IR;
      jisr_pkg::TAP_EXIT1_IR: tap_next = m ? jisr_pkg::TAP_UPD_IR   : jisr_pkg::TAP_PAUSE_IR;
      jisr_pkg::TAP_PAUSE_IR: tap_next = m ? jisr_pkg::TAP_EXIT2_IR : jisr_pkg::TAP_PAUSE_IR;
      jisr_pkg::TAP_EXIT2_IR: tap_next = m ? jisr_pkg::TAP_UPD_IR   : jisr_pkg::TAP_SHIFT_IR;
      jisr_pkg::TAP_UPD_IR:   tap_next = m ? jisr_pkg::TAP_SEL_DR   : jisr_pkg::TAP_IDLE;
      default:                tap_next = jisr_pkg::TAP_RESET;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Link side: capture, shift and update
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_lk     = lk_ff;
    nxt_lk.tap = tap_next(lk_ff.tap, tms);
    case (lk_ff.tap)
      jisr_pkg::TAP_RESET: begin
        nxt_lk.ir = jisr_pkg::INS_IDCODE;
      end
      jisr_pkg::TAP_CAP_IR: begin
        // The low bits are fixed; bit 2 tells the controller a pulse still runs.
        nxt_lk.ir_sh = {7'h00, link_busy, jisr_pkg::IR_CAP_LOW};
      end
      jisr_pkg::TAP_SHIFT_IR: begin
        nxt_lk.ir_sh = {tdi, lk_ff.ir_sh[jisr_pkg::IR_LEN-1:1]};
      end
      jisr_pkg::TAP_UPD_IR: begin
        nxt_lk.ir = lk_ff.ir_sh;
        // Entry, exit and erase need no data, so their pulse starts here.
        if (!link_busy) begin
          case (lk_ff.ir_sh)
            jisr_pkg::INS_ENTER: begin
              nxt_lk.kind    = jisr_pkg::PK_ENTER;
              nxt_lk.req_tog = ~lk_ff.req_tog;
            end
            jisr_pkg::INS_EXIT: begin
              nxt_lk.kind    = jisr_pkg::PK_EXIT;
              nxt_lk.req_tog = ~lk_ff.req_tog;
            end
            jisr_pkg::INS_ERASE: begin
              nxt_lk.kind    = jisr_pkg::PK_ERASE;
              nxt_lk.req_tog = ~lk_ff.req_tog;
            end
            default: begin
              nxt_lk.kind = lk_ff.kind;
            end
          endcase
        end
      end
      jisr_pkg::TAP_CAP_DR: begin
        nxt_lk.byp = 1'b0;
        case (lk_ff.ir)
          jisr_pkg::INS_IDCODE:   nxt_lk.dr32 = id_value;
          jisr_pkg::INS_USERCODE: nxt_lk.dr32 = user_code;
          jisr_pkg::INS_PROGRAM:  nxt_lk.dr32 = lk_ff.word;
          jisr_pkg::INS_VERIFY:   nxt_lk.dr32 = {lk_ff.word[31:16], sy_ff.rdata};
          jisr_pkg::INS_EXTEST:   nxt_lk.bsr_sh = bsr_pins_in;
          jisr_pkg::INS_SAMPLE:   nxt_lk.bsr_sh = bsr_pins_in;
          default:                nxt_lk.byp = 1'b0;
        endcase
      end
      jisr_pkg::TAP_SHIFT_DR: begin
        nxt_lk.dr32   = {tdi, lk_ff.dr32[jisr_pkg::ID_LEN-1:1]};
        nxt_lk.bsr_sh = {tdi, lk_ff.bsr_sh[BSR_LEN-1:1]};
        nxt_lk.byp    = tdi;
      end
      jisr_pkg::TAP_UPD_DR: begin
        if ((lk_ff.ir == jisr_pkg::INS_EXTEST) || (lk_ff.ir == jisr_pkg::INS_SAMPLE)) begin
          nxt_lk.bsr_upd = lk_ff.bsr_sh;
        end
        // The word stays frozen while the system side works on it.
        if (!link_busy && (lk_ff.ir == jisr_pkg::INS_PROGRAM)) begin
          nxt_lk.word    = lk_ff.dr32;
          nxt_lk.kind    = jisr_pkg::PK_PROGRAM;
          nxt_lk.req_tog = ~lk_ff.req_tog;
        end else if (!link_busy && (lk_ff.ir == jisr_pkg::INS_VERIFY)) begin
          nxt_lk.word    = lk_ff.dr32;
          nxt_lk.kind    = jisr_pkg::PK_VERIFY;
          nxt_lk.req_tog = ~lk_ff.req_tog;
        end
      end
      default: begin
        nxt_lk.tap = tap_next(lk_ff.tap, tms);
      end
    endcase
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      lk_ff     <= '0;
      lk_ff.tap <= jisr_pkg::TAP_RESET;
      lk_ff.ir  <= jisr_pkg::INS_IDCODE;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // TDO changes on the falling edge so the controller samples it stable.
  always_comb begin
    case (lk_ff.ir)
      jisr_pkg::INS_IDCODE, jisr_pkg::INS_USERCODE,
      jisr_pkg::INS_PROGRAM, jisr_pkg::INS_VERIFY: nxt_tdo = lk_ff.dr32[0];
      jisr_pkg::INS_EXTEST, jisr_pkg::INS_SAMPLE:  nxt_tdo = lk_ff.bsr_sh[0];
      default:                                      nxt_tdo = lk_ff.byp;
    endcase
    if (lk_ff.tap == jisr_pkg::TAP_SHIFT_IR) begin
      nxt_tdo = lk_ff.ir_sh[0];
    end
  end

  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff    <= nxt_tdo;
      tdo_oe_ff <= (lk_ff.tap == jisr_pkg::TAP_SHIFT_IR) || (lk_ff.tap == jisr_pkg::TAP_SHIFT_DR);
    end
  end

  // ----------------------------------------------------------------------
  // System side: timed pulses
  // ----------------------------------------------------------------------
  function automatic logic [jisr_pkg::CNT_W-1:0] pulse_len(jisr_pkg::jisr_pulse_type k);
    case (k)
      jisr_pkg::PK_ENTER:   pulse_len = jisr_pkg::CNT_W'(MODE_CYC - 1);
      jisr_pkg::PK_EXIT:    pulse_len = jisr_pkg::CNT_W'(MODE_CYC - 1);
      jisr_pkg::PK_ERASE:   pulse_len = jisr_pkg::CNT_W'(ERASE_CYC - 1);
      jisr_pkg::PK_PROGRAM: pulse_len = jisr_pkg::CNT_W'(jisr_pkg::PROGRAM_CYC - 1);
      jisr_pkg::PK_VERIFY:  pulse_len = jisr_pkg::CNT_W'(jisr_pkg::READ_CYC - 1);
      default:              pulse_len = '0;
    endcase
  endfunction

  // Kind and word are read across domains only while the toggle handshake
  // guarantees they are frozen on the link side.
  always_comb begin
    nxt_sy = sy_ff;
    if (!sy_ff.busy && (req_seen != sy_ff.ack_tog)) begin
      nxt_sy.busy  = 1'b1;
      nxt_sy.kind  = lk_ff.kind;
      nxt_sy.cnt   = pulse_len(lk_ff.kind);
      nxt_sy.addr  = lk_ff.word[31:16];
      nxt_sy.wdata = lk_ff.word[15:0];
    end else if (sy_ff.busy && (sy_ff.cnt != '0)) begin
      nxt_sy.cnt = sy_ff.cnt - 1'b1;
    end else if (sy_ff.busy) begin
      nxt_sy.busy    = 1'b0;
      nxt_sy.ack_tog = ~sy_ff.ack_tog;
      case (sy_ff.kind)
        jisr_pkg::PK_ENTER:  nxt_sy.mode  = 1'b1;
        jisr_pkg::PK_EXIT:   nxt_sy.mode  = 1'b0;
        jisr_pkg::PK_VERIFY: nxt_sy.rdata = cell_rdata;
        default:             nxt_sy.mode  = sy_ff.mode;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sy_ff <= '0;
    end else begin
      sy_ff <= nxt_sy;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign tdo                        = tdo_ff;
  assign tdo_oe                     = tdo_oe_ff;
  assign bsr_pins_out               = lk_ff.bsr_upd;
  assign extest_en                  = (lk_ff.ir == jisr_pkg::INS_EXTEST);
  assign in_system_programming_mode = sy_ff.mode;
  assign erase_pulse                = sy_ff.busy && (sy_ff.kind == jisr_pkg::PK_ERASE);
  assign program_pulse              = sy_ff.busy && (sy_ff.kind == jisr_pkg::PK_PROGRAM);
  assign read_pulse                 = sy_ff.busy && (sy_ff.kind == jisr_pkg::PK_VERIFY);
  assign cell_addr                  = sy_ff.addr;
  assign cell_wdata                 = sy_ff.wdata;

endmodule

// >>> tb/jisr_ctrl_model.sv
// Model of the external scan and programming controller.
`timescale 1ns/1ns
module jisr_ctrl_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  int unsigned shift_cycles;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    shift_cycles = 0;
  end
  // The link clock only runs inside these tasks; tdo is taken just before the rise.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #24;
    q = tdo;
    tck = 1'b1;
    #24;
    tck = 1'b0;
    shift_cycles++;
  endtask
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // From Idle through a shift of len bits, least significant first, back to Idle.
  task automatic scan(input logic is_ir, input int len, input logic [127:0] din, output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (is_ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule

// >>> tb/jisr_top_props.sv
// Port-level assertions of the scan and programming port.
`timescale 1ns/1ns
module jisr_top_props #(
  parameter int BSR_LEN   = jisr_pkg::BSR_LEN,
  parameter int ERASE_CYC = jisr_pkg::ERASE_CYC
) (
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tdo_oe,
  input wire logic [BSR_LEN-1:0] bsr_pins_out,
  input wire logic               in_system_programming_mode,
  input wire logic               erase_pulse,
  input wire logic               program_pulse,
  input wire logic               read_pulse,
  input wire logic [15:0]        cell_addr,
  input wire logic [15:0]        cell_wdata
);
  // Pulses run far longer than a repetition may unroll, so their length is counted here.
  int unsigned run_ff;
  int unsigned nxt_run;
  always_comb nxt_run = (erase_pulse | program_pulse | read_pulse) ? run_ff + 1 : 0;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      run_ff <= 0;
    else
      run_ff <= nxt_run;

  a_pulse_one_hot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $onehot0({erase_pulse, program_pulse, read_pulse})) else $error("two pulses at once");
  a_erase_len_exact: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(erase_pulse) |-> run_ff == ERASE_CYC) else $error("erase pulse length wrong");
  a_prog_len_exact: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(program_pulse) |-> run_ff == jisr_pkg::PROGRAM_CYC) else $error("program pulse length wrong");
  a_read_len_exact: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(read_pulse) |-> run_ff == jisr_pkg::READ_CYC) else $error("read pulse length wrong");
  a_cell_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    program_pulse && $past(program_pulse) |-> $stable(cell_addr) && $stable(cell_wdata))
    else $error("cell address or data moved in pulse");
  a_mode_steady: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (erase_pulse | program_pulse | read_pulse) |-> $stable(in_system_programming_mode))
    else $error("mode changed during a cell pulse");
  a_oe_reset_low: assert property (@(posedge tck) disable iff (!rst_n)
    tms [*5] |-> !tdo_oe) else $error("tdo driven after five tms ones");
  a_bsr_upd_quiet: assert property (@(posedge tck) disable iff (!rst_n)
    !$stable(bsr_pins_out) |-> !tdo_oe) else $error("pin register moved while shifting");

  c_erase: cover property (@(posedge clk_sys) $rose(erase_pulse));
  c_prog: cover property (@(posedge clk_sys) $rose(program_pulse));
  c_read: cover property (@(posedge clk_sys) $rose(read_pulse));
  c_mode: cover property (@(posedge clk_sys) $rose(in_system_programming_mode));
endmodule

bind jisr_top jisr_top_props #(.BSR_LEN(BSR_LEN), .ERASE_CYC(ERASE_CYC)) i_jisr_top_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdo_oe(tdo_oe), .bsr_pins_out(bsr_pins_out),
  .in_system_programming_mode(in_system_programming_mode), .erase_pulse(erase_pulse),
  .program_pulse(program_pulse), .read_pulse(read_pulse), .cell_addr(cell_addr), .cell_wdata(cell_wdata));

// >>> tb/jisr_top_tb.sv
// Self-checking bench of the scan port and programming pulse engine.
`timescale 1ns/1ns
module jisr_top_tb;
  localparam int          BSR_N   = 96;
  localparam logic [3:0]  TB_VER  = 4'h9;     // Arbitrary identification value.
  localparam logic [15:0] TB_PART = 16'h5E17; // Arbitrary identification value.
  localparam logic [10:0] TB_MFR  = 11'h1A3;  // Arbitrary identification value.
  logic             clk_sys, rst_n, tck, tms, tdi, tdo, tdo_oe, ext_en, mode, erase_p, prog_p, read_p, tdo_line;
  logic [31:0]      user_code, seed;
  logic [BSR_N-1:0] bsr_in, bsr_out;
  logic [15:0]      cell_addr, cell_wdata, cell_rdata, a;
  logic [127:0]     din, dout;
  logic [9:0]       cap;
  int               err_total, checked, er_cyc, pr_cyc, rd_cyc, n0;

  jisr_top #(.BSR_LEN(BSR_N), .MODE_CYC(20), .ERASE_CYC(40), .ID_VER(TB_VER), .ID_PART(TB_PART),
    .ID_MFR(TB_MFR)) i_jisr_top (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .user_code(user_code), .bsr_pins_in(bsr_in), .bsr_pins_out(bsr_out),
    .extest_en(ext_en), .in_system_programming_mode(mode), .erase_pulse(erase_p), .program_pulse(prog_p),
    .read_pulse(read_p), .cell_addr(cell_addr), .cell_wdata(cell_wdata), .cell_rdata(cell_rdata));
  // A released line shows the inverse, so a late or early output enable is caught.
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  jisr_ctrl_model i_jisr_ctrl_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

  always #25 clk_sys = ~clk_sys;
  // Sampled on the falling edge, clear of the edge that launches the pulses.
  always @(negedge clk_sys) begin
    er_cyc += erase_p;
    pr_cyc += prog_p;
    rd_cyc += read_p;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_id();
    return {TB_VER, TB_PART, TB_MFR, 1'b1};
  endfunction
  function automatic logic [9:0] exp_cap(input logic busy);
    return {7'h00, busy, 2'h1};
  endfunction
  task automatic test_done();
    $display("errors %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic ir(input logic [9:0] code);
    i_jisr_ctrl_model.scan(1'b1, jisr_pkg::IR_LEN, {118'h0, code}, dout);
    cap = dout[9:0];
  endtask
  // Polls the busy bit of the instruction capture; the first capture is kept in cap0.
  task automatic wait_idle(output logic [9:0] cap0);
    ir(jisr_pkg::INS_BYPASS);
    cap0 = cap;
    for (int n = 0; n < 400 && cap[2] !== 1'b0; n++)
      ir(jisr_pkg::INS_BYPASS);
    if (cap[2] !== 1'b0) begin
      chk(1, 0, "pulse never ended");
      test_done();
    end
  endtask

  initial begin
    {clk_sys, rst_n, user_code, bsr_in, cell_rdata} = '0;
    {err_total, checked, er_cyc, pr_cyc, rd_cyc} = '0;
    seed = 32'hD0C1;
    fork
      i_jisr_ctrl_model.tap_reset();
      repeat (6) @(negedge clk_sys);
    join
    rst_n = 1'b1;
    i_jisr_ctrl_model.tap_reset();
    i_jisr_ctrl_model.scan(1'b0, 64, {64'h0, xs(), xs()}, din);
    chk(din[31:0], exp_id(), "id after reset");
    i_jisr_ctrl_model.scan(1'b1, 20, {108'h0, jisr_pkg::INS_USERCODE, jisr_pkg::INS_USERCODE}, dout);
    chk(dout[9:0], exp_cap(1'b0), "ir capture");
    chk(dout[19:10], jisr_pkg::INS_USERCODE, "ir length");
    @(negedge clk_sys);
    user_code = xs();
    bsr_in = {xs(), xs(), xs()};
    din = {xs(), xs(), xs(), xs()};
    i_jisr_ctrl_model.scan(1'b0, 64, din, dout);
    chk(dout[63:0], {din[31:0], user_code}, "user code");
    for (int k = 0; k < 2; k++) begin
      ir(k == 0 ? jisr_pkg::INS_BYPASS : 10'h155);
      i_jisr_ctrl_model.scan(1'b0, 33, din, dout);
      chk(dout[32:0], {din[31:0], 1'b0}, "bypass");
    end
    for (int k = 0; k < 2; k++) begin
      ir(k == 0 ? jisr_pkg::INS_SAMPLE : jisr_pkg::INS_EXTEST);
      chk(ext_en, k, "extest");
      din = {xs(), xs(), xs(), xs()};
      i_jisr_ctrl_model.scan(1'b0, BSR_N + 32, din, dout);
      chk(dout[BSR_N+31:0], {din[31:0], bsr_in}, "scan chain");
      chk(bsr_out, din[BSR_N+31:32], "pin update");
    end
    ir(jisr_pkg::INS_ENTER);
    wait_idle(cap);
    chk(cap, exp_cap(1'b1), "busy in entry");
    chk({mode, ext_en}, 2'h2, "mode on");
    n0 = i_jisr_ctrl_model.shift_cycles;
    ir(jisr_pkg::INS_IDCODE);
    chk(i_jisr_ctrl_model.shift_cycles - n0, jisr_pkg::IR_LEN + 6, "shift budget");
    i_jisr_ctrl_model.scan(1'b0, 32, din, dout);
    chk(dout[31:0], exp_id(), "id check");
    er_cyc = 0;
    ir(jisr_pkg::INS_ERASE);
    ir(jisr_pkg::INS_ERASE);
    wait_idle(cap);
    chk(er_cyc, 40, "one erase pulse");
    a = 16'(xs());
    din = {96'h0, a, 16'(xs())};
    pr_cyc = 0;
    ir(jisr_pkg::INS_PROGRAM);
    i_jisr_ctrl_model.scan(1'b0, 32, din, dout);
    for (int n = 0; n < 100 && prog_p !== 1'b1; n++)
      @(negedge clk_sys);
    chk(prog_p, 1'b1, "program start");
    chk({cell_addr, cell_wdata}, din[31:0], "cell word");
    wait_idle(cap);
    chk(pr_cyc, jisr_pkg::PROGRAM_CYC, "program pulse");
    @(negedge clk_sys);
    cell_rdata = 16'(xs());
    rd_cyc = 0;
    ir(jisr_pkg::INS_VERIFY);
    i_jisr_ctrl_model.scan(1'b0, 32, {96'h0, ~a, 16'h0}, dout);
    wait_idle(cap);
    chk(rd_cyc, jisr_pkg::READ_CYC, "read pulse");
    ir(jisr_pkg::INS_VERIFY);
    i_jisr_ctrl_model.scan(1'b0, 32, din, dout);
    chk(dout[31:0], {~a, cell_rdata}, "verify data");
    wait_idle(cap);
    ir(jisr_pkg::INS_EXIT);
    wait_idle(cap);
    chk(mode, 1'b0, "mode off");
    // Stand-alone check of the stored word, with no erase or program in between.
    @(negedge clk_sys);
    cell_rdata = 16'(xs());
    {er_cyc, pr_cyc} = '0;
    ir(jisr_pkg::INS_ENTER);
    wait_idle(cap);
    ir(jisr_pkg::INS_IDCODE);
    i_jisr_ctrl_model.scan(1'b0, 32, din, dout);
    chk(dout[31:0], exp_id(), "lone id check");
    ir(jisr_pkg::INS_VERIFY);
    i_jisr_ctrl_model.scan(1'b0, 32, {96'h0, a, 16'h0}, dout);
    wait_idle(cap);
    ir(jisr_pkg::INS_VERIFY);
    i_jisr_ctrl_model.scan(1'b0, 32, din, dout);
    chk(dout[31:0], {a, cell_rdata}, "lone verify");
    wait_idle(cap);
    ir(jisr_pkg::INS_EXIT);
    wait_idle(cap);
    chk({mode, er_cyc, pr_cyc}, 65'h0, "lone exit without erase or program");
    test_done();
  end
endmodule
